// ### hw/tbmc_device.sv
// mode sequencer and output control of the six-channel bias device.
// assumes supply rails arrive as clean synchronous levels on clk_sys.
`timescale 1ns/1ps
module tbmc_device #(
    parameter logic [1:0] LOWPOWER_CODE = tbmc_pkg::PM_LOWPOWER_DEF,
    parameter logic [1:0] RESET_CODE = tbmc_pkg::PM_RESET_DEF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // supply rails
    input wire logic io_supply_rail,
    input wire logic analog_supply_rail,
    // register link
    tbmc_link_if.device link,
    // channel outputs
    output logic [41:0] chan_code_q,
    output logic [5:0] chan_drive_q,
    output logic [5:0] chan_pulldown_q,
    // boost and mode
    output logic boost_on_q,
    output logic [3:0] boost_level_q,
    output logic [1:0] mode_code_q
);
    tbmc_pkg::tbmc_mode_type mode_q;
    tbmc_pkg::tbmc_mode_type mode_d;
    logic analog_supply_rail_prev_q;
    logic por_armed_q;
    logic [3:0] start_cnt_q;
    logic [5:0] enable_q;
    logic [7:0] rdata_q;
    logic alive_q;
    logic [6:0] code_w [0:5];

    // supply events; the armed power-on waits out a same-cycle analog edge
    wire io_rise = io_supply_rail & por_armed_q;
    wire analog_supply_rail_rise = analog_supply_rail & ~analog_supply_rail_prev_q;
    wire force_off = ~io_supply_rail | ~analog_supply_rail | analog_supply_rail_rise;

    // mode decode
    wire in_sd = (mode_q == tbmc_pkg::MODE_SHUTDOWN);
    wire in_start = (mode_q == tbmc_pkg::MODE_STARTUP);
    wire in_act = (mode_q == tbmc_pkg::MODE_ACTIVE);
    wire in_low = (mode_q == tbmc_pkg::MODE_LOWPOWER);
    wire start_done = in_start & (start_cnt_q == tbmc_pkg::STARTUP_LAST);

    // power field commands from the controller
    wire wr_ok = link.reg_wr & ~in_sd & ~force_off;
    wire wr_power = wr_ok & (link.reg_addr == tbmc_pkg::REG_POWER);
    wire [1:0] pm_req = link.reg_wdata[1:0];
    wire cmd_reset = wr_power & (in_act | in_low) & (pm_req == RESET_CODE); // RULE_11 RULE_19
    wire cmd_low = wr_power & in_act & (pm_req == LOWPOWER_CODE) & ~cmd_reset; // RULE_13 RULE_19
    wire cmd_act = wr_power & in_low & (pm_req == tbmc_pkg::PM_ACTIVE) & ~cmd_reset; // RULE_15

    // defaults are forced while off and on every entry to startup
    wire regs_clear = force_off | in_sd | io_rise | cmd_reset; // RULE_06 RULE_08 RULE_17
    wire wr_boost = wr_ok & (link.reg_addr == tbmc_pkg::REG_BOOST);
    wire wr_enable = wr_ok & (link.reg_addr == tbmc_pkg::REG_ENABLE);
    wire out_live = in_act; // RULE_12 RULE_14

    // mode read-back code
    wire [1:0] mode_field = in_start ? tbmc_pkg::PM_STARTUP :
                            in_low ? LOWPOWER_CODE : tbmc_pkg::PM_ACTIVE; // RULE_10

    // read selection; unmapped indices and shutdown read as zero
    wire rd_code = (link.reg_addr >= tbmc_pkg::REG_CODE_A) &
                   (link.reg_addr <= tbmc_pkg::REG_LAST);
    wire [3:0] code_idx = link.reg_addr - tbmc_pkg::REG_CODE_A;
    wire [7:0] rd_sel = (link.reg_addr == tbmc_pkg::REG_BOOST) ? {4'h0, boost_level_q} :
                        (link.reg_addr == tbmc_pkg::REG_POWER) ? {6'h00, mode_field} :
                        (link.reg_addr == tbmc_pkg::REG_ENABLE) ? {2'h0, enable_q} :
                        rd_code ? {1'b0, code_w[code_idx[2:0]]} : 8'h00;
    wire [7:0] rd_next = (link.reg_rd & ~in_sd & ~force_off) ? rd_sel : 8'h00;

    // next mode; supply loss beats every command
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            tbmc_pkg::MODE_SHUTDOWN: begin
                if (io_rise) begin
                    mode_d = tbmc_pkg::MODE_STARTUP; // RULE_08
                end
            end
            tbmc_pkg::MODE_STARTUP: begin
                if (start_done) begin
                    mode_d = tbmc_pkg::MODE_ACTIVE; // RULE_09
                end
            end
            tbmc_pkg::MODE_ACTIVE: begin
                if (cmd_reset) begin
                    mode_d = tbmc_pkg::MODE_STARTUP;
                end else if (cmd_low) begin
                    mode_d = tbmc_pkg::MODE_LOWPOWER;
                end
            end
            tbmc_pkg::MODE_LOWPOWER: begin
                if (cmd_reset) begin
                    mode_d = tbmc_pkg::MODE_STARTUP;
                end else if (cmd_act) begin
                    mode_d = tbmc_pkg::MODE_ACTIVE;
                end
            end
            default: begin
                mode_d = tbmc_pkg::MODE_SHUTDOWN;
            end
        endcase
        if (force_off) begin
            mode_d = tbmc_pkg::MODE_SHUTDOWN; // RULE_07
        end
    end

    // mode register and startup dwell counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= tbmc_pkg::MODE_SHUTDOWN;
            start_cnt_q <= 4'h0;
        end else begin
            mode_q <= mode_d;
            if (mode_d == tbmc_pkg::MODE_STARTUP && !in_start) begin
                start_cnt_q <= 4'h0;
            end else if (in_start && !start_done) begin
                start_cnt_q <= start_cnt_q + 4'h1;
            end
        end
    end

    // supply edge tracking; the power-on is re-armed only by a real low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            analog_supply_rail_prev_q <= 1'b0;
            por_armed_q <= 1'b1;
        end else begin
            analog_supply_rail_prev_q <= analog_supply_rail;
            if (!io_supply_rail) begin
                por_armed_q <= 1'b1; // RULE_18
            end else if (io_rise & ~force_off) begin
                por_armed_q <= 1'b0; // RULE_18
            end
        end
    end

    // boost level and enable mask; a write loses to any reset source
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            boost_level_q <= tbmc_pkg::BOOST_RST;
            enable_q <= tbmc_pkg::ENABLE_RST;
        end else if (regs_clear) begin
            boost_level_q <= tbmc_pkg::BOOST_RST; // RULE_03
            enable_q <= tbmc_pkg::ENABLE_RST; // RULE_16
        end else begin
            if (wr_boost) begin
                boost_level_q <= link.reg_wdata[3:0]; // RULE_02
            end
            if (wr_enable) begin
                enable_q <= link.reg_wdata[5:0];
            end
        end
    end

    // boost runs in startup and active, stops in low power and shutdown
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            boost_on_q <= 1'b0;
            mode_code_q <= tbmc_pkg::PM_ACTIVE;
        end else begin
            boost_on_q <= (mode_d == tbmc_pkg::MODE_STARTUP) |
                          (mode_d == tbmc_pkg::MODE_ACTIVE); // RULE_08 RULE_14
            mode_code_q <= mode_field;
        end
    end

    // link answer: read data stand for the one cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
            alive_q <= 1'b0;
        end else begin
            rdata_q <= rd_next;
            alive_q <= ~force_off & (mode_d != tbmc_pkg::MODE_SHUTDOWN);
        end
    end
    assign link.reg_rdata = rdata_q;
    assign link.link_alive = alive_q;

    // per-channel code store and output stage
    genvar ch;
    generate
        for (ch = 0; ch < tbmc_pkg::NUM_CH; ch++) begin : g_ch
            logic [6:0] code_q;
            logic [6:0] out_code_q;
            logic drive_q;
            logic pull_q;
            wire wr_code = wr_ok & (link.reg_addr == tbmc_pkg::REG_CODE_A + 4'(ch));
            wire is_zero = (code_q == tbmc_pkg::CODE_OFF);
            wire on_req = out_live & enable_q[ch];

            // code store, kept through low power
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    code_q <= tbmc_pkg::CODE_RST;
                end else if (regs_clear) begin
                    code_q <= tbmc_pkg::CODE_RST; // RULE_06
                end else if (wr_code) begin
                    code_q <= link.reg_wdata[6:0]; // RULE_01
                end
            end

            // drive, pull-down, or neither for high impedance
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    drive_q <= 1'b0;
                    pull_q <= 1'b0;
                    out_code_q <= tbmc_pkg::CODE_OFF;
                end else begin
                    drive_q <= on_req & ~is_zero; // RULE_12
                    pull_q <= on_req & is_zero; // RULE_05
                    out_code_q <= (on_req & ~is_zero) ? code_q : tbmc_pkg::CODE_OFF;
                end
            end

            assign code_w[ch] = code_q;
            assign chan_code_q[ch*7 +: 7] = out_code_q;
            assign chan_drive_q[ch] = drive_q;
            assign chan_pulldown_q[ch] = pull_q;
        end
    endgenerate
endmodule

// ### hw/tbmc_pkg.sv
// constants, register map and mode type of the tuner bias mode controller.
// assumes one 100 MHz clock shared by the controller and the device end.
// Behaviour
// RULE_01 - six channel codes, 128 levels, 188 mV
// RULE_02 - four-bit boost level, 9 V to 24 V
// RULE_03 - boost level resets to all ones
// RULE_04 - host keeps boost 2 V above outputs
// RULE_05 - code zero pulls the output to ground
// RULE_06 - shutdown: everything off, outputs high impedance
// RULE_07 - shutdown on analog rise or IO low
// RULE_08 - IO rise: startup, defaults, boost on, high-Z
// RULE_09 - startup moves to active by itself
// RULE_10 - mode field reads 01 then 00
// RULE_11 - host reset command returns device to startup
// RULE_12 - active outputs follow codes once enabled
// RULE_13 - host command moves active to low power
// RULE_14 - low power: interface on, outputs off, kept
// RULE_15 - host command moves low power to active
// RULE_16 - channel enable mask resets to zeros
// RULE_17 - power-on also resets the interface logic
// RULE_18 - power-on fires only after supply was low
// RULE_19 - low-power and reset codes are parameters
package tbmc_pkg;
    // widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 6;
    localparam int CODE_W = 7;
    localparam int BOOST_W = 4;
    localparam int MODE_W = 2;
    // device register indices
    localparam logic [3:0] REG_BOOST = 4'h0;
    localparam logic [3:0] REG_POWER = 4'h1;
    localparam logic [3:0] REG_ENABLE = 4'h2;
    localparam logic [3:0] REG_CODE_A = 4'h3;
    localparam logic [3:0] REG_LAST = 4'h8;
    // reset values
    localparam logic [3:0] BOOST_RST = 4'hF;
    localparam logic [5:0] ENABLE_RST = 6'h00;
    localparam logic [6:0] CODE_RST = 7'h00;
    localparam logic [6:0] CODE_OFF = 7'h00;
    // power mode field codes
    localparam logic [1:0] PM_ACTIVE = 2'h0;
    localparam logic [1:0] PM_STARTUP = 2'h1;
    localparam logic [1:0] PM_LOWPOWER_DEF = 2'h2;
    localparam logic [1:0] PM_RESET_DEF = 2'h1;
    // startup dwell
    localparam int CLK_PERIOD_NS = 10;
    localparam int STARTUP_TIME_NS = 40;
    localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] STARTUP_LAST = 4'(STARTUP_CYCLES - 1);
    // voltage arithmetic in millivolts
    localparam logic [16:0] CODE_STEP_MV = 17'h000BC;
    localparam logic [16:0] BOOST_BASE_MV = 17'h02328;
    localparam logic [16:0] BOOST_STEP_MV = 17'h003E8;
    localparam logic [16:0] HEADROOM_MV = 17'h007D0;
    // controller register indices and status bits
    localparam logic [1:0] HREG_TARGET = 2'h0;
    localparam logic [1:0] HREG_DATA = 2'h1;
    localparam logic [1:0] HREG_CMD = 2'h2;
    localparam logic [1:0] HREG_STATUS = 2'h3;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_WARN = 2;
    localparam int ST_ALIVE = 3;
    localparam int CMD_READ = 0;

    typedef enum logic [1:0] {
        MODE_SHUTDOWN,
        MODE_STARTUP,
        MODE_ACTIVE,
        MODE_LOWPOWER
    } tbmc_mode_type;
endpackage

// ### hw/tbmc_link_if.sv
// register link between the controller and the bias device.
// assumes both ends run on the same clock; the bench joins them here.
`timescale 1ns/1ps
interface tbmc_link_if;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic link_alive;

    // device answers, controller drives
    modport device (
        input reg_addr,
        input reg_wdata,
        input reg_wr,
        input reg_rd,
        output reg_rdata,
        output link_alive
    );
    modport host (
        output reg_addr,
        output reg_wdata,
        output reg_wr,
        output reg_rd,
        input reg_rdata,
        input link_alive
    );
endinterface

// ### hw/tbmc_host.sv
// controller end: turns local register writes into link transfers
// and watches the boost headroom of what it sends.
// assumes the device answers a read in the cycle after the strobe.
`timescale 1ns/1ps
module tbmc_host #(
    parameter logic [1:0] RESET_CODE = tbmc_pkg::PM_RESET_DEF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // software port
    input wire logic [1:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata_q,
    // register link
    tbmc_link_if.host link
);
    logic [3:0] target_q;
    logic [3:0] addr_q;
    logic [7:0] wdata_q;
    logic wr_q;
    logic rd_q;
    logic wait_q;
    logic [7:0] rdbuf_q;
    logic done_q;
    logic warn_q;
    logic [3:0] boost_sh_q;
    logic [6:0] max_code_q;

    // local decode
    wire w_target = cpu_wr & (cpu_addr == tbmc_pkg::HREG_TARGET);
    wire w_data = cpu_wr & (cpu_addr == tbmc_pkg::HREG_DATA);
    wire w_read = cpu_wr & (cpu_addr == tbmc_pkg::HREG_CMD) & cpu_wdata[tbmc_pkg::CMD_READ];
    wire w_status = cpu_wr & (cpu_addr == tbmc_pkg::HREG_STATUS);
    wire busy = rd_q | wait_q;
    wire [7:0] status = {4'h0, link.link_alive, warn_q, done_q, busy};

    // shadow tracking of what went out on the link
    wire sent_boost = wr_q & (addr_q == tbmc_pkg::REG_BOOST);
    wire sent_reset = wr_q & (addr_q == tbmc_pkg::REG_POWER) & (wdata_q[1:0] == RESET_CODE);
    wire sent_code = wr_q & (addr_q >= tbmc_pkg::REG_CODE_A) & (addr_q <= tbmc_pkg::REG_LAST);
    wire [3:0] boost_new = sent_boost ? wdata_q[3:0] : boost_sh_q;
    wire [6:0] code_new = (sent_code && wdata_q[6:0] > max_code_q) ? wdata_q[6:0] : max_code_q;
    wire [16:0] out_mv = 17'(code_new * tbmc_pkg::CODE_STEP_MV);
    wire [16:0] boost_mv = 17'(tbmc_pkg::BOOST_BASE_MV + boost_new * tbmc_pkg::BOOST_STEP_MV);
    wire short_room = (sent_boost | sent_code) & (out_mv + tbmc_pkg::HEADROOM_MV > boost_mv);

    // local read selection
    wire [7:0] cpu_sel = (cpu_addr == tbmc_pkg::HREG_TARGET) ? {4'h0, target_q} :
                         (cpu_addr == tbmc_pkg::HREG_DATA) ? rdbuf_q :
                         (cpu_addr == tbmc_pkg::HREG_STATUS) ? status : 8'h00;

    // link strobes: one cycle each, a read already in flight holds new reads off
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            target_q <= 4'h0;
            addr_q <= 4'h0;
            wdata_q <= 8'h00;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            wait_q <= 1'b0;
        end else begin
            if (w_target) begin
                target_q <= cpu_wdata[3:0];
            end
            wr_q <= w_data & ~busy;
            rd_q <= w_read & ~busy & ~w_data;
            wait_q <= rd_q;
            if ((w_data | w_read) & ~busy) begin
                addr_q <= target_q;
                wdata_q <= cpu_wdata;
            end
        end
    end

    // read capture, sticky flags (set beats clear), headroom shadows
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdbuf_q <= 8'h00;
            done_q <= 1'b0;
            warn_q <= 1'b0;
            boost_sh_q <= tbmc_pkg::BOOST_RST;
            max_code_q <= tbmc_pkg::CODE_RST;
            cpu_rdata_q <= 8'h00;
        end else begin
            if (wait_q) begin
                rdbuf_q <= link.reg_rdata;
            end
            done_q <= wait_q | (done_q & ~(w_status & cpu_wdata[tbmc_pkg::ST_DONE]));
            warn_q <= short_room | (warn_q & ~(w_status & cpu_wdata[tbmc_pkg::ST_WARN])); // RULE_04
            if (sent_reset) begin
                boost_sh_q <= tbmc_pkg::BOOST_RST; // RULE_11
                max_code_q <= tbmc_pkg::CODE_RST;
            end else begin
                boost_sh_q <= boost_new;
                max_code_q <= code_new;
            end
            cpu_rdata_q <= cpu_rd ? cpu_sel : 8'h00;
        end
    end

    assign link.reg_addr = addr_q;
    assign link.reg_wdata = wdata_q;
    assign link.reg_wr = wr_q;
    assign link.reg_rd = rd_q;
endmodule

// ### verif/tbmc_checker.sv
// concurrent checks on the link and the device outputs of the bias controller.
// assumes one clock domain and the bench's asynchronous active-low reset.
`timescale 1ns/1ps
module tbmc_checker (
    // clock, reset and rails
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic io_supply_rail,
    // register link
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic link_alive,
    // device outputs
    input wire logic [41:0] chan_code_q,
    input wire logic [5:0] chan_drive_q,
    input wire logic [5:0] chan_pulldown_q,
    input wire logic boost_on_q,
    input wire logic [3:0] boost_level_q,
    input wire logic [1:0] mode_code_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // named mode decodes keep the properties short
    wire in_start = (mode_code_q == tbmc_pkg::PM_STARTUP);
    wire in_low = (mode_code_q == tbmc_pkg::PM_LOWPOWER_DEF);
    wire outs_off = (chan_drive_q == 6'h00) && (chan_pulldown_q == 6'h00);
    // startup lasts exactly four cycles, then active without a command
    startup_dwell_a: assert property (
        $rose(in_start) |-> in_start [*4] ##1 !in_start && mode_code_q == tbmc_pkg::PM_ACTIVE)
        else $error("startup length wrong");
    // the boost register is back at all ones on entry to startup
    startup_default_a: assert property (
        $rose(in_start) |-> boost_level_q == 4'hF) else $error("boost default wrong");
    // startup keeps outputs high impedance with the boost running
    startup_hiz_a: assert property (
        in_start |-> outs_off && boost_on_q) else $error("startup outputs not off");
    // a channel is never driven and pulled down at once
    drive_excl_a: assert property (
        (chan_drive_q & chan_pulldown_q) == 6'h00) else $error("drive and pulldown together");
    // codes stay zero while no channel is driven
    code_gate_a: assert property (
        chan_drive_q == 6'h00 |-> chan_code_q == 42'h0) else $error("code on idle output");
    // low power: outputs off, boost off, link alive; boost leads the mode field a cycle
    lowpower_off_a: assert property (
        in_low |-> outs_off && link_alive && !$past(boost_on_q))
        else $error("low power state wrong");
    // low power is reached from active only
    lowpower_entry_a: assert property (
        $rose(in_low) |-> $past(mode_code_q) == tbmc_pkg::PM_ACTIVE)
        else $error("low power entry wrong");
    // io supply low stops boost and link next cycle, outputs the cycle after
    io_shutdown_a: assert property (
        !io_supply_rail |-> ##1 !boost_on_q && !link_alive ##1 outs_off)
        else $error("io low not shut down");
    // read data stands only in the slot after a read strobe
    rdata_slot_a: assert property (
        reg_rdata != 8'h00 |-> $past(reg_rd)) else $error("read data out of slot");
    // main scenarios
    cover property ($rose(in_start));
    cover property ($rose(in_low));
    cover property (chan_pulldown_q != 6'h00);
    cover property (reg_rdata != 8'h00);
endmodule

// ### verif/tuner_bias_mode_control_tb.sv
// self-checking bench: controller and device joined by the link interface.
// assumes the default power codes of both ends; one 100 MHz clock.
`timescale 1ns/1ps
module tuner_bias_mode_control_tb;
    logic clk_sys, rst_n, io_supply_rail, analog_supply_rail;
    logic [1:0] cpu_addr;
    logic [7:0] cpu_wdata, cpu_rdata_q;
    logic cpu_wr, cpu_rd, rd_seen, smp;
    logic [41:0] chan_code_q;
    logic [5:0] chan_drive_q, chan_pulldown_q, enm;
    logic boost_on_q, warn, done, alv;
    logic [3:0] boost_level_q, boostv;
    logic [1:0] mode_code_q;
    logic [6:0] code [6];
    logic [6:0] maxc;
    logic [7:0] rdq [$];
    logic [61:0] oq [$];
    logic [61:0] note;
    logic [31:0] v;
    integer seed;
    int errors, n_compared;

    tbmc_link_if i_tbmc_link_if ();
    tbmc_device i_tbmc_device (.clk_sys(clk_sys), .rst_n(rst_n), .io_supply_rail(io_supply_rail),
        .analog_supply_rail(analog_supply_rail), .link(i_tbmc_link_if), .chan_code_q(chan_code_q),
        .chan_drive_q(chan_drive_q), .chan_pulldown_q(chan_pulldown_q), .boost_on_q(boost_on_q),
        .boost_level_q(boost_level_q), .mode_code_q(mode_code_q));
    tbmc_host i_tbmc_host (.clk_sys(clk_sys), .rst_n(rst_n), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata_q(cpu_rdata_q),
        .link(i_tbmc_link_if));
    tbmc_checker i_tbmc_checker (.clk_sys(clk_sys), .rst_n(rst_n), .io_supply_rail(io_supply_rail),
        .reg_rd(i_tbmc_link_if.reg_rd), .reg_rdata(i_tbmc_link_if.reg_rdata),
        .link_alive(i_tbmc_link_if.link_alive), .chan_code_q(chan_code_q),
        .chan_drive_q(chan_drive_q), .chan_pulldown_q(chan_pulldown_q), .boost_on_q(boost_on_q),
        .boost_level_q(boost_level_q), .mode_code_q(mode_code_q));

    // free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input string nm, input logic [63:0] s, input logic [63:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // software port cycles; one idle edge between strobes of the same task
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'b1;
        @(posedge clk_sys);
        cpu_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        rdq.push_back(e);
        @(posedge clk_sys);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge clk_sys);
        cpu_rd <= 1'b0;
    endtask

    // device register write through the controller, with the expected model
    task automatic dwr(input logic [3:0] idx, input logic [7:0] d);
        wr(tbmc_pkg::HREG_TARGET, {4'h0, idx});
        wr(tbmc_pkg::HREG_DATA, d);
        if (idx == tbmc_pkg::REG_BOOST) boostv = d[3:0];
        if (idx == tbmc_pkg::REG_ENABLE) enm = d[5:0];
        if (idx >= tbmc_pkg::REG_CODE_A && idx <= tbmc_pkg::REG_LAST) begin
            code[idx - tbmc_pkg::REG_CODE_A] = d[6:0];
            if (d[6:0] > maxc) maxc = d[6:0];
        end
        if (idx == tbmc_pkg::REG_BOOST || idx >= tbmc_pkg::REG_CODE_A)
            warn = warn | ((int'(maxc) * 188 + 2000) > (9000 + int'(boostv) * 1000));
    endtask
    // link read: the buffer is ready three edges after the command
    task automatic drd(input logic [3:0] idx, input logic [7:0] e);
        wr(tbmc_pkg::HREG_TARGET, {4'h0, idx});
        wr(tbmc_pkg::HREG_CMD, 8'h01);
        repeat (3) @(posedge clk_sys);
        rd(tbmc_pkg::HREG_DATA, e);
        done = 1'b1;
    endtask
    function automatic logic [7:0] stat();
        return {4'h0, alv, warn, done, 1'b0};
    endfunction
    task automatic dflt;
        boostv = 4'hF;
        enm = 6'h00;
        for (int i = 0; i < 6; i++) code[i] = 7'h00;
    endtask

    // note the expected outputs, then flag the monitor for one cycle
    task automatic chk_out(input logic [1:0] m, input logic bon, input logic live);
        logic [5:0] nz;
        logic [41:0] cx;
        repeat (4) @(posedge clk_sys);
        cx = 42'h0;
        for (int i = 0; i < 6; i++) begin
            nz[i] = (code[i] != 7'h00);
            if (live && enm[i] && nz[i]) cx[i*7 +: 7] = code[i];
        end
        oq.push_back({cx, live ? enm & nz : 6'h00, live ? enm & ~nz : 6'h00, bon, boostv, m, alv});
        smp <= 1'b1;
        @(posedge clk_sys);
        smp <= 1'b0;
    endtask

    // monitors take the oldest note whenever a result stands
    always @(negedge clk_sys) begin
        if (smp === 1'b1) begin
            note = oq.pop_front();
            check("outputs", {2'h0, chan_code_q, chan_drive_q, chan_pulldown_q, boost_on_q,
                boost_level_q, mode_code_q, i_tbmc_link_if.link_alive}, {2'h0, note});
        end
    end
    always @(posedge clk_sys) begin
        if (rd_seen === 1'b1) check("rdata", {56'h0, cpu_rdata_q}, {56'h0, rdq.pop_front()});
        rd_seen <= cpu_rd;
    end

    // watchdog well beyond the expected run length
    initial begin
        #100000;
        errors++;
        summarize();
    end

    initial begin
        seed = 32'h2b4ce66e;
        errors = 0;
        n_compared = 0;
        {cpu_addr, cpu_wdata, cpu_wr, cpu_rd, rd_seen, smp} = '0;
        {warn, done, maxc} = '0;
        alv = 1'b1;
        dflt();
        rst_n = 1'b0;
        io_supply_rail = 1'b1;
        analog_supply_rail = 1'b1;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (12) @(posedge clk_sys);
        chk_out(tbmc_pkg::PM_ACTIVE, 1'b1, 1'b1);
        drd(tbmc_pkg::REG_BOOST, 8'h0F);
        drd(tbmc_pkg::REG_POWER, 8'h00);
        drd(tbmc_pkg::REG_ENABLE, 8'h00);
        drd(4'hF, 8'h00);
        rd(tbmc_pkg::HREG_STATUS, stat());
        $display("test defaults done");
        // random codes, zero codes frequent, random enables
        for (int r = 0; r < 4; r++) begin
            for (int c = 0; c < 6; c++) begin
                v = $random(seed);
                dwr(4'(tbmc_pkg::REG_CODE_A + c), (v[1:0] == 2'h0) ? 8'h00 : {2'h0, v[8:3]});
            end
            v = $random(seed);
            dwr(tbmc_pkg::REG_ENABLE, {2'h0, v[5:0]});
            chk_out(tbmc_pkg::PM_ACTIVE, 1'b1, 1'b1);
        end
        drd(tbmc_pkg::REG_LAST, {1'b0, code[5]});
        $display("test channel outputs done");
        dwr(tbmc_pkg::REG_POWER, {6'h0, tbmc_pkg::PM_LOWPOWER_DEF});
        chk_out(tbmc_pkg::PM_LOWPOWER_DEF, 1'b0, 1'b0);
        drd(tbmc_pkg::REG_ENABLE, {2'h0, enm});
        dwr(tbmc_pkg::REG_POWER, 8'h00);
        chk_out(tbmc_pkg::PM_ACTIVE, 1'b1, 1'b1);
        $display("test low power done");
        dwr(tbmc_pkg::REG_BOOST, 8'h00);
        dwr(tbmc_pkg::REG_CODE_A, 8'h28);
        chk_out(tbmc_pkg::PM_ACTIVE, 1'b1, 1'b1);
        rd(tbmc_pkg::HREG_STATUS, stat());
        wr(tbmc_pkg::HREG_STATUS, 8'h06);
        {warn, done} = 2'b00;
        rd(tbmc_pkg::HREG_STATUS, stat());
        $display("test headroom done");
        dwr(tbmc_pkg::REG_ENABLE, 8'h3F);
        dwr(tbmc_pkg::REG_POWER, {6'h0, tbmc_pkg::PM_RESET_DEF});
        dflt();
        maxc = 7'h00;
        repeat (8) @(posedge clk_sys);
        chk_out(tbmc_pkg::PM_ACTIVE, 1'b1, 1'b1);
        drd(tbmc_pkg::REG_BOOST, 8'h0F);
        $display("test reset command done");
        dwr(tbmc_pkg::REG_CODE_A, 8'h10);
        dwr(tbmc_pkg::REG_ENABLE, 8'h01);
        chk_out(tbmc_pkg::PM_ACTIVE, 1'b1, 1'b1);
        analog_supply_rail <= 1'b0;
        dflt();
        alv = 1'b0;
        chk_out(tbmc_pkg::PM_ACTIVE, 1'b0, 1'b0);
        analog_supply_rail <= 1'b1;
        repeat (12) @(posedge clk_sys);
        chk_out(tbmc_pkg::PM_ACTIVE, 1'b0, 1'b0);
        drd(tbmc_pkg::REG_BOOST, 8'h00);
        io_supply_rail <= 1'b0;
        chk_out(tbmc_pkg::PM_ACTIVE, 1'b0, 1'b0);
        io_supply_rail <= 1'b1;
        alv = 1'b1;
        repeat (12) @(posedge clk_sys);
        chk_out(tbmc_pkg::PM_ACTIVE, 1'b1, 1'b1);
        drd(tbmc_pkg::REG_ENABLE, 8'h00);
        $display("test supply events done");
        summarize();
    end
endmodule
